//--- design/gpt_pkg.sv
// constants, field layout and state type of the 32-bit general purpose timer
// ****************************************************************************
// ****************************************************************************
`default_nettype none
package gpt_pkg;
    localparam logic [31:0] GPT_ADDR_RELOAD = 32'hffff0320;
    localparam logic [31:0] GPT_ADDR_COUNT = 32'hffff0324;
    localparam logic [31:0] GPT_ADDR_CONTROL = 32'hffff0328;
    localparam logic [31:0] GPT_ADDR_CLEAR = 32'hffff032c;
    localparam logic [31:0] GPT_ADDR_CAPTURE = 32'hffff0330;
    localparam logic [31:0] GPT_RESET_WORD = 32'h0;
    localparam int GPT_POST_LSB = 24;
    localparam int GPT_POST_WE = 23;
    localparam int GPT_CMP_FLAG = 19;
    localparam int GPT_IRQ_SEL = 18;
    localparam int GPT_CAP_EN = 17;
    localparam int GPT_EVT_LSB = 12;
    localparam int GPT_SRC_LSB = 9;
    localparam int GPT_UP = 8;
    localparam int GPT_EN = 7;
    localparam int GPT_PERIODIC = 6;
    localparam int GPT_FMT_LSB = 4;
    localparam int GPT_PRE_LSB = 0;
    localparam logic [31:0] GPT_CTRL_WMASK = 32'h0007ffff;
    localparam logic [2:0] GPT_SRC_OSC = 3'h0;
    localparam logic [2:0] GPT_SRC_CORE = 3'h1;
    localparam logic [2:0] GPT_SRC_PLL = 3'h2;
    localparam logic [2:0] GPT_SRC_GPIO = 3'h3;
    localparam logic [1:0] GPT_FMT_HMS23 = 2'h2;
    localparam logic [1:0] GPT_FMT_HMS255 = 2'h3;
    localparam logic [4:0] GPT_EVT_MAX = 5'h11;
    localparam int GPT_EVT_NUM = 18;
    localparam logic [7:0] GPT_HUND_MAX = 8'h63;
    localparam logic [7:0] GPT_SIXTY_MAX = 8'h3b;
    localparam logic [7:0] GPT_HOUR23_MAX = 8'h17;
    localparam logic [7:0] GPT_HOUR255_MAX = 8'hff;
    localparam logic [3:0] GPT_PRE_16 = 4'h4;
    localparam logic [3:0] GPT_PRE_256 = 4'h8;
    localparam logic [3:0] GPT_PRE_32768 = 4'hf;
    localparam logic [14:0] GPT_MASK_1 = 15'h0000;
    localparam logic [14:0] GPT_MASK_16 = 15'h000f;
    localparam logic [14:0] GPT_MASK_256 = 15'h00ff;
    localparam logic [14:0] GPT_MASK_32768 = 15'h7fff;
    localparam logic [1:0] GPT_RESP_OKAY = 2'h0;
    localparam logic [1:0] GPT_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0] osc_sync;
        logic [2:0] pll_sync;
        logic [2:0] gpio_sync;
        logic [17:0] evt_prev;
        logic [14:0] pre_cnt;
        logic [7:0] post_cnt;
        logic [31:0] reload;
        logic [31:0] count;
        logic [31:0] ctrl;
        logic [31:0] capture;
        logic irq;
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gpt_state_s;
endpackage
`default_nettype wire

//--- design/gpt_timer.sv
// 32-bit general purpose timer with capture and postscaler, axi4-lite slave
`default_nettype none
module gpt_timer (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic osc32k_in,
    input wire logic undivided_pll_clock_in,
    input wire logic gpio_count_input_in,
    input wire logic low_power_in,
    input wire logic [17:0] irq_sources_in,
    output logic timer_irq_out,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    import gpt_pkg::*;

    // ************************************************************************
    // helpers
    // ************************************************************************
    // register index: 1..5 for mapped words, 0 for unmapped
    function automatic logic [2:0] reg_index(input logic [31:0] addr);
        logic [2:0] idx;
        idx = 3'h0;
        if (addr == GPT_ADDR_RELOAD) begin
            idx = 3'h1;
        end else if (addr == GPT_ADDR_COUNT) begin
            idx = 3'h2;
        end else if (addr == GPT_ADDR_CONTROL) begin
            idx = 3'h3;
        end else if (addr == GPT_ADDR_CLEAR) begin
            idx = 3'h4;
        end else if (addr == GPT_ADDR_CAPTURE) begin
            idx = 3'h5;
        end
        return idx;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    // unlisted prescaler codes fall back to divide by one
    function automatic logic [14:0] pre_mask(input logic [3:0] code);
        logic [14:0] m;
        case (code)
            GPT_PRE_16: m = GPT_MASK_16;
            GPT_PRE_256: m = GPT_MASK_256;
            GPT_PRE_32768: m = GPT_MASK_32768;
            default: m = GPT_MASK_1;
        endcase
        return m;
    endfunction

    // clock-time step; fields hours 31:24, minutes 23:16, seconds 15:8, hundredths 7:0
    function automatic logic [32:0] hms_step(input logic [31:0] v,
                                             input logic up,
                                             input logic [7:0] hour_max);
        logic [31:0] res;
        logic carry;
        logic [7:0] lim;
        logic [7:0] f;
        res = v;
        carry = 1'b1;
        lim = GPT_HUND_MAX;
        f = 8'h0;
        for (int i = 0; i < 4; i++) begin
            lim = (i == 0) ? GPT_HUND_MAX : ((i == 3) ? hour_max : GPT_SIXTY_MAX);
            f = v[8*i +: 8];
            if (carry) begin
                if (up) begin
                    if (f >= lim) begin
                        res[8*i +: 8] = 8'h0;
                    end else begin
                        res[8*i +: 8] = f + 8'h1;
                        carry = 1'b0;
                    end
                end else begin
                    if (f == 8'h0) begin
                        res[8*i +: 8] = lim;
                    end else begin
                        res[8*i +: 8] = f - 8'h1;
                        carry = 1'b0;
                    end
                end
            end
        end
        return {carry, res};
    endfunction

    // ************************************************************************
    // reset release
    // ************************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ************************************************************************
    // state
    // ************************************************************************
    gpt_state_s cur;
    gpt_state_s next;

    logic [2:0] src_sel;
    logic [1:0] fmt;
    logic src_tick;
    logic count_tick;
    logic [32:0] step;
    logic ovf;
    logic [4:0] evt_sel;
    logic evt_fire;
    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;
    logic do_write;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic clear_wr;
    logic [31:0] merged;

    assign s_axi_awready_out = !cur.aw_held && !cur.bvalid;
    assign s_axi_wready_out = !cur.w_held && !cur.bvalid;
    assign s_axi_arready_out = !cur.rvalid;
    assign s_axi_bvalid_out = cur.bvalid;
    assign s_axi_bresp_out = cur.bresp;
    assign s_axi_rvalid_out = cur.rvalid;
    assign s_axi_rdata_out = cur.rdata;
    assign s_axi_rresp_out = cur.rresp;
    assign timer_irq_out = cur.irq;

    always_comb begin
        next = cur;
        src_sel = cur.ctrl[GPT_SRC_LSB +: 3];
        fmt = cur.ctrl[GPT_FMT_LSB +: 2];

        // pins pass three flops; the second and third stages feed the edge detect
        next.osc_sync = {cur.osc_sync[1:0], osc32k_in};
        next.pll_sync = {cur.pll_sync[1:0], undivided_pll_clock_in};
        next.gpio_sync = {cur.gpio_sync[1:0], gpio_count_input_in};

        // ********************************************************************
        // source and prescaler
        // ********************************************************************
        // the pll clock is sampled, so it only counts while slower than clk_in/2
        case (src_sel)
            GPT_SRC_OSC: src_tick = cur.osc_sync[1] && !cur.osc_sync[2];
            GPT_SRC_CORE: src_tick = 1'b1;
            GPT_SRC_PLL: src_tick = cur.pll_sync[1] && !cur.pll_sync[2];
            GPT_SRC_GPIO: src_tick = cur.gpio_sync[1] && !cur.gpio_sync[2];
            default: src_tick = 1'b0;
        endcase
        if (low_power_in && src_sel != GPT_SRC_OSC && src_sel != GPT_SRC_GPIO) begin
            src_tick = 1'b0;
        end
        if (!cur.ctrl[GPT_EN]) begin
            src_tick = 1'b0;
        end

        count_tick = 1'b0;
        if (src_tick) begin
            if ((cur.pre_cnt & pre_mask(cur.ctrl[GPT_PRE_LSB +: 4])) ==
                pre_mask(cur.ctrl[GPT_PRE_LSB +: 4])) begin
                next.pre_cnt = 15'h0;
                count_tick = 1'b1;
            end else begin
                next.pre_cnt = cur.pre_cnt + 15'h1;
            end
        end

        // ********************************************************************
        // counter
        // ********************************************************************
        if (fmt == GPT_FMT_HMS23) begin
            step = hms_step(cur.count, cur.ctrl[GPT_UP], GPT_HOUR23_MAX);
        end else if (fmt == GPT_FMT_HMS255) begin
            step = hms_step(cur.count, cur.ctrl[GPT_UP], GPT_HOUR255_MAX);
        end else if (cur.ctrl[GPT_UP]) begin
            step = {1'b0, cur.count} + 33'h1;
        end else begin
            step = {cur.count == 32'h0, cur.count - 32'h1};
        end
        ovf = count_tick && step[32];
        if (count_tick) begin
            if (ovf && cur.ctrl[GPT_PERIODIC]) begin
                next.count = cur.reload;
            end else begin
                next.count = step[31:0];
            end
        end

        // ********************************************************************
        // capture on each rising edge of the chosen source
        // ********************************************************************
        next.evt_prev = irq_sources_in;
        evt_sel = cur.ctrl[GPT_EVT_LSB +: 5];
        evt_fire = 1'b0;
        if (evt_sel <= GPT_EVT_MAX) begin
            evt_fire = irq_sources_in[evt_sel] && !cur.evt_prev[evt_sel];
        end
        if (cur.ctrl[GPT_CAP_EN] && evt_fire) begin
            next.capture = cur.count;
        end

        // ********************************************************************
        // bus write
        // ********************************************************************
        aw_take = s_axi_awvalid_in && s_axi_awready_out;
        w_take = s_axi_wvalid_in && s_axi_wready_out;
        aw_have = cur.aw_held || aw_take;
        w_have = cur.w_held || w_take;
        wr_addr = cur.aw_held ? cur.aw_addr : s_axi_awaddr_in;
        wr_data = cur.w_held ? cur.w_data : s_axi_wdata_in;
        wr_strb = cur.w_held ? cur.w_strb : s_axi_wstrb_in;
        do_write = aw_have && w_have;
        wr_idx = reg_index(wr_addr);
        clear_wr = 1'b0;
        merged = merge(cur.ctrl, wr_data, wr_strb);
        if (aw_take) begin
            next.aw_held = 1'b1;
            next.aw_addr = s_axi_awaddr_in;
        end
        if (w_take) begin
            next.w_held = 1'b1;
            next.w_data = s_axi_wdata_in;
            next.w_strb = s_axi_wstrb_in;
        end
        if (do_write) begin
            next.aw_held = 1'b0;
            next.w_held = 1'b0;
            next.bvalid = 1'b1;
            next.bresp = GPT_RESP_OKAY;
            if (wr_idx == 3'h1) begin
                next.reload = merge(cur.reload, wr_data, wr_strb);
            end else if (wr_idx == 3'h3) begin
                next.ctrl = (merged & GPT_CTRL_WMASK) | (cur.ctrl & ~GPT_CTRL_WMASK);
                if (wr_strb[2] && wr_data[GPT_POST_WE] && wr_strb[3]) begin
                    next.ctrl[GPT_POST_LSB +: 8] = wr_data[GPT_POST_LSB +: 8];
                end
                next.ctrl[GPT_POST_WE] = 1'b0;
                next.ctrl[22:20] = 3'h0;
            end else if (wr_idx == 3'h4) begin
                clear_wr = 1'b1;
            end else if (wr_idx == 3'h0) begin
                next.bresp = GPT_RESP_SLVERR;
            end
        end
        if (cur.bvalid && s_axi_bready_in) begin
            next.bvalid = 1'b0;
        end

        // a clear write wins over a count step in the same cycle
        if (clear_wr) begin
            next.count = cur.reload;
            next.pre_cnt = 15'h0;
            next.irq = 1'b0;
            next.ctrl[GPT_CMP_FLAG] = 1'b0;
        end

        // ********************************************************************
        // interrupt and postscaler; a set here beats the clear above
        // ********************************************************************
        if (ovf) begin
            if (cur.ctrl[GPT_IRQ_SEL]) begin
                if (cur.post_cnt == cur.ctrl[GPT_POST_LSB +: 8]) begin
                    next.post_cnt = 8'h0;
                    next.ctrl[GPT_CMP_FLAG] = 1'b1;
                    next.irq = 1'b1;
                end else begin
                    next.post_cnt = cur.post_cnt + 8'h1;
                end
            end else begin
                next.irq = 1'b1;
            end
        end

        // ********************************************************************
        // bus read
        // ********************************************************************
        rd_idx = reg_index(s_axi_araddr_in);
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            next.rvalid = 1'b1;
            next.rresp = GPT_RESP_OKAY;
            if (rd_idx == 3'h1) begin
                next.rdata = cur.reload;
            end else if (rd_idx == 3'h2) begin
                next.rdata = cur.count;
            end else if (rd_idx == 3'h3) begin
                next.rdata = cur.ctrl;
            end else if (rd_idx == 3'h5) begin
                next.rdata = cur.capture;
            end else if (rd_idx == 3'h4) begin
                next.rdata = GPT_RESET_WORD;
            end else begin
                next.rdata = GPT_RESET_WORD;
                next.rresp = GPT_RESP_SLVERR;
            end
        end else if (cur.rvalid && s_axi_rready_in) begin
            next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end
endmodule
`default_nettype wire

//--- testbench/gpt_timer_props.sv
// bus and interrupt assertions for the general purpose timer
`default_nettype none
module gpt_timer_props (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic timer_irq_out,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    import gpt_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    logic aw_hs;
    logic w_hs;
    logic mapped;
    assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
    assign w_hs = s_axi_wvalid_in && s_axi_wready_out;
    assign mapped = s_axi_araddr_in >= GPT_ADDR_RELOAD && s_axi_araddr_in <= GPT_ADDR_CAPTURE
        && s_axi_araddr_in[1:0] == 2'h0;
    sequence s_wr_take;
        aw_hs && w_hs;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    AST_B_ANSWER: assert property (s_wr_take |=> s_axi_bvalid_out)
        else $error("write response late");
    AST_B_STANDS: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    AST_R_ANSWER: assert property (s_rd_take |=> s_axi_rvalid_out)
        else $error("read response late");
    AST_R_STANDS: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
        else $error("read response dropped");
    AST_W_REFUSED: assert property (s_axi_bvalid_out |-> !aw_hs && !w_hs)
        else $error("write taken while response pending");
    AST_AR_REFUSED: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read taken while response pending");
    AST_UNMAPPED: assert property (s_rd_take and !mapped |=>
        s_axi_rresp_out == GPT_RESP_SLVERR && s_axi_rdata_out == 32'h0)
        else $error("unmapped read answered wrongly");
    AST_CLEAR_READ: assert property (s_rd_take and s_axi_araddr_in == GPT_ADDR_CLEAR |=>
        s_axi_rdata_out == 32'h0 && s_axi_rresp_out == GPT_RESP_OKAY)
        else $error("clear register read wrongly");
    AST_IRQ_FALL: assert property ($fell(timer_irq_out) && $past(reset_n_in) |->
        $past(aw_hs || w_hs))
        else $error("interrupt dropped without a write");
endmodule
bind gpt_timer gpt_timer_props u_props (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .timer_irq_out(timer_irq_out),
    .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in)
);
`default_nettype wire

//--- testbench/tb_general_purpose_timer_32bit.sv
// self-checking bench for the 32-bit general purpose timer
`default_nettype none
module tb_general_purpose_timer_32bit;
    timeunit 1ns;
    timeprecision 1ns;
    import gpt_pkg::*;
    logic clk = '0, rst_n = '0, lp = '0, awvalid = '0, wvalid = '0, bready = '0;
    logic arvalid = '0, rready = '0, awready, wready, bvalid, arready, rvalid, irq;
    logic [3:0] pin = '0, wstrb = '0;
    logic [17:0] evt = '0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd_d;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    int fails = 0, compares = 0, cyc = 0;
    gpt_timer u_dut (
        .clk_in(clk), .reset_n_in(rst_n), .osc32k_in(pin[0]), .undivided_pll_clock_in(pin[2]),
        .gpio_count_input_in(pin[3]), .low_power_in(lp), .irq_sources_in(evt),
        .timer_irq_out(irq), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready)
    );
    initial forever #50 clk = ~clk;
    // the longest test waits out one /32768 prescaler period
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude();
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ****************************************************************
    // bus cycles: handshakes judged at the falling edge, acted on at the next rise
    // ****************************************************************
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            wr_r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        logic ta, tr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            rd_d = rdata;
            rd_r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_d, e);
    endtask
    // one rising edge on the source pin of the given select code
    task automatic pulse(input logic [2:0] k);
        @(posedge clk);
        pin[k] <= 1'b1;
        repeat (4) @(posedge clk);
        pin <= '0;
        repeat (5) @(posedge clk);
    endtask
    // clock-time digits roll over at their limits in both directions
    function automatic logic [32:0] step(input logic [31:0] c, input logic up, input logic per,
                                         input logic [31:0] rl, input logic [1:0] f);
        logic [31:0] n;
        logic cy;
        logic [7:0] lm;
        n = up ? c + 32'h1 : c - 32'h1;
        cy = up ? &c : ~|c;
        if (f[1]) begin
            n = c;
            cy = 1'b1;
            for (int i = 0; i < 4; i++) begin
                lm = i == 3 ? (f[0] ? 8'hff : 8'h17) : (i == 0 ? 8'h63 : 8'h3b);
                if (cy) n[8*i+:8] = up ? (c[8*i+:8] == lm ? 8'h0 : c[8*i+:8] + 8'h1)
                                       : (c[8*i+:8] == 8'h0 ? lm : c[8*i+:8] - 8'h1);
                cy = cy && c[8*i+:8] == (up ? lm : 8'h0);
            end
        end
        if (cy && per) n = rl;
        return {cy, n};
    endfunction
    initial begin
        logic [31:0] c, r;
        logic [32:0] s;
        logic ov;
        int k;
        logic [31:0] rl [7] = '{32'h2, 32'h2, 32'hfffffffe, 32'hfffffffe, 32'h173b3b63,
                                32'h173b3b63, 32'h0};
        logic [11:0] cf [7] = '{12'h080, 12'h0c0, 12'h580, 12'h7c0, 12'h1a0, 12'h1b0,
                                12'h0a0};
        void'($urandom(32'h238a));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 5; i++) rchk(GPT_ADDR_RELOAD + 32'(4 * i), '0);
        rchk(32'hffff0334, '0);
        chk(rd_r, GPT_RESP_SLVERR);
        wr(32'hffff0334, 32'h1);
        chk(wr_r, GPT_RESP_SLVERR);
        wr(GPT_ADDR_COUNT, 32'h5);
        rchk(GPT_ADDR_COUNT, '0);
        wr(GPT_ADDR_CONTROL, 32'hffffffff);
        rchk(GPT_ADDR_CONTROL, 32'hff07ffff);
        wr(GPT_ADDR_CONTROL, '0);
        rchk(GPT_ADDR_CONTROL, 32'hff000000);
        wr(GPT_ADDR_CONTROL, 32'h00800000);
        rchk(GPT_ADDR_CONTROL, '0);
        r = '0;
        repeat (6) begin
            c = $urandom;
            k = $urandom % 16;
            wr(GPT_ADDR_RELOAD, c, 4'(k));
            for (int b = 0; b < 4; b++) if (k[b]) r[8*b+:8] = c[8*b+:8];
            rchk(GPT_ADDR_RELOAD, r);
            wr(GPT_ADDR_CLEAR, c);
            rchk(GPT_ADDR_COUNT, r);
        end
        for (int i = 0; i < 7; i++) begin
            wr(GPT_ADDR_CONTROL, {20'h0, cf[i]});
            wr(GPT_ADDR_RELOAD, rl[i]);
            wr(GPT_ADDR_CLEAR, '0);
            c = rl[i];
            ov = 1'b0;
            repeat (4) begin
                pulse(cf[i][11:9]);
                s = step(c, cf[i][8], cf[i][6], rl[i], cf[i][5:4]);
                c = s[31:0];
                ov |= s[32];
                rchk(GPT_ADDR_COUNT, c);
                chk(irq, ov);
            end
            wr(GPT_ADDR_CLEAR, '0);
            chk(irq, 1'b0);
        end
        wr(GPT_ADDR_RELOAD, 32'h64);
        for (int i = 0; i < 2; i++) begin
            wr(GPT_ADDR_CONTROL, i ? 32'h88 : 32'h84);
            wr(GPT_ADDR_CLEAR, '0);
            repeat (i ? 255 : 15) pulse(3'h0);
            rchk(GPT_ADDR_COUNT, 32'h64);
            pulse(3'h0);
            rchk(GPT_ADDR_COUNT, 32'h63);
        end
        wr(GPT_ADDR_CONTROL, 32'h28f);
        wr(GPT_ADDR_CLEAR, '0);
        repeat (32700) @(posedge clk);
        rchk(GPT_ADDR_COUNT, 32'h64);
        repeat (100) @(posedge clk);
        rchk(GPT_ADDR_COUNT, 32'h63);
        lp <= 1'b1;
        wr(GPT_ADDR_CONTROL, 32'h280);
        wr(GPT_ADDR_CLEAR, '0);
        repeat (20) @(posedge clk);
        rchk(GPT_ADDR_COUNT, 32'h64);
        wr(GPT_ADDR_CONTROL, 32'h680);
        pulse(3'h3);
        rchk(GPT_ADDR_COUNT, 32'h63);
        wr(GPT_ADDR_CONTROL, 32'h80);
        pulse(3'h0);
        rchk(GPT_ADDR_COUNT, 32'h62);
        lp <= 1'b0;
        k = $urandom % 18;
        r = $urandom;
        wr(GPT_ADDR_RELOAD, r);
        wr(GPT_ADDR_CONTROL, 32'h20080 | (32'(k) << 12));
        wr(GPT_ADDR_CLEAR, '0);
        evt[k] <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(GPT_ADDR_CAPTURE, r);
        rchk(GPT_ADDR_COUNT, r);
        pulse(3'h0);
        evt[(k + 1) % 18] <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(GPT_ADDR_CAPTURE, r);
        wr(GPT_ADDR_CONTROL, 32'h80 | (32'(k) << 12));
        evt <= '0;
        repeat (3) @(posedge clk);
        evt[k] <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(GPT_ADDR_CAPTURE, r);
        evt <= '0;
        wr(GPT_ADDR_RELOAD, '0);
        wr(GPT_ADDR_CONTROL, 32'h018400c0);
        wr(GPT_ADDR_CLEAR, '0);
        pulse(3'h0);
        chk(irq, 1'b0);
        pulse(3'h0);
        chk(irq, 1'b1);
        rchk(GPT_ADDR_CONTROL, 32'h010c00c0);
        wr(GPT_ADDR_CLEAR, '0);
        rchk(GPT_ADDR_CONTROL, 32'h010400c0);
        conclude();
    end
endmodule
`default_nettype wire
